// ---- design/pac_channel.v ----
// One 8-bit channel counter with left or center alignment and its output.
`include "pac_defines.vh"
`default_nettype none
module pac_channel (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire                   tick,
    input  wire                   enable,
    input  wire                   center,
    input  wire                   polarity,
    input  wire                   cnt_clear,
    input  wire [`PAC_CNT_W-1:0]  period,
    input  wire [`PAC_CNT_W-1:0]  duty,
    output reg  [`PAC_CNT_W-1:0]  count,
    output reg                    wave
);
    reg down;
    always @(posedge clk) begin
        if (sys_rst || cnt_clear) begin
            count <= `PAC_RST_BYTE;
            down  <= 1'b0;
        end else if (enable && tick) begin
            if (!center) begin
                // Left alignment wraps one below the period.
                if (count + `PAC_CNT_ONE >= period) begin
                    count <= `PAC_RST_BYTE;
                end else begin
                    count <= count + `PAC_CNT_ONE;
                end
                down <= 1'b0;
            end else if (!down) begin
                if (count >= period) begin
                    down  <= 1'b1;
                    count <= count - `PAC_CNT_ONE;
                end else begin
                    count <= count + `PAC_CNT_ONE;
                end
            end else begin
                if (count == `PAC_RST_BYTE) begin
                    down  <= 1'b0;
                    count <= count + `PAC_CNT_ONE;
                end else begin
                    count <= count - `PAC_CNT_ONE;
                end
            end
        end
    end
    always @(posedge clk) begin
        if (sys_rst) begin
            wave <= 1'b0;
        end else begin
            wave <= (count < duty) ? polarity : ~polarity;
        end
    end
endmodule // pac_channel
`default_nettype wire

// ---- design/pac_defines.vh ----
// Register offsets, field positions, reset values and widths of the slice.
`ifndef PAC_DEFINES_VH
`define PAC_DEFINES_VH
`define PAC_ADDR_W        8
`define PAC_OFF_ALIGN     8'h00
`define PAC_OFF_CTRL      8'h04
`define PAC_OFF_ENABLE    8'h08
`define PAC_OFF_POLARITY  8'h0C
`define PAC_OFF_CLKSEL    8'h10
`define PAC_OFF_CNTWR     8'h14
`define PAC_OFF_STATUS    8'h18
`define PAC_BIT_PAIR67    7
`define PAC_BIT_PAIR45    6
`define PAC_BIT_PAIR23    5
`define PAC_BIT_PAIR01    4
`define PAC_BIT_WAITSTOP  3
`define PAC_BIT_FRZSTOP   2
`define PAC_CTRL_MASK     8'hFC
`define PAC_RST_BYTE      8'h00
`define PAC_RST_WORD      32'h0000_0000
`define PAC_RESP_OKAY     2'b00
`define PAC_RESP_SLVERR   2'b10
`define PAC_CNT_W         8
`define PAC_CNT_ONE       8'h01
`define PAC_RST_HALF      16'h0000
`define PAC_HALF_ONE      16'h0001
`endif

// ---- design/pac_sync2.v ----
// Two-flip-flop synchroniser for one level from outside the clock domain.
`default_nettype none
module pac_sync2 (
    input  wire clk,
    input  wire sys_rst,
    input  wire din,
    output reg  dout
);
    reg meta;
    always @(posedge clk) begin
        if (sys_rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // pac_sync2
`default_nettype wire

// ---- design/pac_top.v ----
// Alignment, pairing and low-power control slice of an eight-channel PWM.
`include "pac_defines.vh"
`default_nettype none
module pac_top (
    input  wire                    clk,
    input  wire                    sys_rst,
    input  wire [`PAC_ADDR_W-1:0]  s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output reg                     s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output reg                     s_axi_wready,
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`PAC_ADDR_W-1:0]  s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output reg                     s_axi_arready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    input  wire                    wait_mode,
    input  wire                    freeze_mode,
    input  wire                    prescale_tick,
    input  wire [63:0]             period_bytes,
    input  wire [63:0]             duty_bytes,
    output reg  [7:0]              pulse_output_port,
    output reg  [7:0]              center_align_bit,
    output reg  [3:0]              pair_mask,
    output reg                     prescaler_clk_en
);
    ////////////////////////////////////////////////////////////////////////
    reg  [7:0]  channel_alignment_select;
    reg  [7:0]  pairing_and_low_power_control;
    reg  [7:0]  channel_enable_bit;
    reg  [7:0]  channel_polarity_bit;
    reg  [7:0]  channel_clock_select_bit;
    reg  [7:0]  cnt_clear;
    reg  [`PAC_ADDR_W-1:0] aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         aw_held;
    reg         w_held;
    wire        wait_sync;
    wire        freeze_sync;
    wire        tick_sync;
    wire [3:0]  pair;
    wire [7:0]  eff_en;
    wire [7:0]  eff_center;
    wire [7:0]  eff_pol;
    wire [7:0]  lo_wave;
    wire        do_write;
    wire [7:0]  wbyte;
    reg  [7:0]  next_rdata;
    reg         next_rerr;
    reg         werr;

    assign pair = {pairing_and_low_power_control[`PAC_BIT_PAIR67],
                   pairing_and_low_power_control[`PAC_BIT_PAIR45],
                   pairing_and_low_power_control[`PAC_BIT_PAIR23],
                   pairing_and_low_power_control[`PAC_BIT_PAIR01]};

    ////////////////////////////////////////////////////////////////////////
    // Mode pins come from the system controller, so they are resynchronised.
    pac_sync2 u_wait (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (wait_mode),
        .dout    (wait_sync)
    );
    pac_sync2 u_frz (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (freeze_mode),
        .dout    (freeze_sync)
    );
    pac_sync2 u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (prescale_tick),
        .dout    (tick_sync)
    );

    // Gating only holds the counters, so counting resumes where it stopped.
    wire clk_run = ~(pairing_and_low_power_control[`PAC_BIT_WAITSTOP]
                     & wait_sync)
                 & ~(pairing_and_low_power_control[`PAC_BIT_FRZSTOP]
                     & freeze_sync);

    ////////////////////////////////////////////////////////////////////////
    // The high channel of a pair takes the odd channel's settings.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pair
            assign eff_en[2*g]       = channel_enable_bit[2*g+1] & pair[g]
                                     | channel_enable_bit[2*g] & ~pair[g];
            assign eff_en[2*g+1]     = channel_enable_bit[2*g+1];
            assign eff_center[2*g]   = pair[g] ? channel_alignment_select[2*g+1]
                                               : channel_alignment_select[2*g];
            assign eff_center[2*g+1] = channel_alignment_select[2*g+1];
            assign eff_pol[2*g]      = pair[g] ? channel_polarity_bit[2*g+1]
                                               : channel_polarity_bit[2*g];
            assign eff_pol[2*g+1]    = channel_polarity_bit[2*g+1];
        end
        for (g = 0; g < 8; g = g + 1) begin : g_ch
            pac_channel u_ch (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .tick      (tick_sync & clk_run),
                .enable    (eff_en[g]),
                .center    (eff_center[g]),
                .polarity  (eff_pol[g]),
                .cnt_clear (cnt_clear[g]),
                .period    (period_bytes[8*g+7:8*g]),
                .duty      (duty_bytes[8*g+7:8*g]),
                .count     (),
                .wave      (lo_wave[g])
            );
        end
        // Paired outputs compare 16 bits; high byte is the even channel.
        for (g = 0; g < 4; g = g + 1) begin : g_out
            wire [15:0] p16 = {period_bytes[16*g+7:16*g],
                               period_bytes[16*g+15:16*g+8]};
            wire [15:0] d16 = {duty_bytes[16*g+7:16*g],
                               duty_bytes[16*g+15:16*g+8]};
            wire        run16 = pair[g] & channel_enable_bit[2*g+1]
                              & tick_sync & clk_run;
            reg  [15:0] c16;
            reg         dn16;
            // A joined pair needs one carry chain, not two byte counters.
            always @(posedge clk) begin
                if (sys_rst || cnt_clear[2*g] || cnt_clear[2*g+1]) begin
                    c16  <= `PAC_RST_HALF;
                    dn16 <= 1'b0;
                end else if (run16 && !eff_center[2*g+1]) begin
                    dn16 <= 1'b0;
                    if (c16 + `PAC_HALF_ONE >= p16) begin
                        c16 <= `PAC_RST_HALF;
                    end else begin
                        c16 <= c16 + `PAC_HALF_ONE;
                    end
                end else if (run16) begin
                    if (dn16 ? (c16 != `PAC_RST_HALF) : (c16 >= p16)) begin
                        dn16 <= 1'b1;
                        c16  <= c16 - `PAC_HALF_ONE;
                    end else begin
                        dn16 <= 1'b0;
                        c16  <= c16 + `PAC_HALF_ONE;
                    end
                end
            end
            always @(posedge clk) begin
                if (sys_rst) begin
                    pulse_output_port[2*g]   <= 1'b0;
                    pulse_output_port[2*g+1] <= 1'b0;
                end else if (pair[g]) begin
                    pulse_output_port[2*g]   <= 1'b0;
                    pulse_output_port[2*g+1] <= channel_enable_bit[2*g+1] &
                        ((c16 < d16) ? eff_pol[2*g+1]
                                     : ~eff_pol[2*g+1]);
                end else begin
                    pulse_output_port[2*g]   <= eff_en[2*g] & lo_wave[2*g];
                    pulse_output_port[2*g+1] <= eff_en[2*g+1] & lo_wave[2*g+1];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path; address and data may arrive in either order.
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    assign wbyte    = w_data[7:0];

    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PAC_RESP_OKAY;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= {`PAC_ADDR_W{1'b0}};
            w_data  <= `PAC_RST_WORD;
            w_strb  <= 4'h0;
            cnt_clear <= `PAC_RST_BYTE;
            channel_alignment_select      <= `PAC_RST_BYTE;
            pairing_and_low_power_control <= `PAC_RST_BYTE;
            channel_enable_bit            <= `PAC_RST_BYTE;
            channel_polarity_bit          <= `PAC_RST_BYTE;
            channel_clock_select_bit      <= `PAC_RST_BYTE;
        end else begin
            cnt_clear <= `PAC_RST_BYTE;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= werr ? `PAC_RESP_SLVERR : `PAC_RESP_OKAY;
                if (w_strb[0]) begin
                    case (aw_addr)
                        `PAC_OFF_ALIGN:
                            channel_alignment_select <= wbyte;
                        `PAC_OFF_CTRL:
                            pairing_and_low_power_control <=
                                wbyte & `PAC_CTRL_MASK;
                        `PAC_OFF_ENABLE:   channel_enable_bit <= wbyte;
                        `PAC_OFF_POLARITY: channel_polarity_bit <= wbyte;
                        `PAC_OFF_CLKSEL:
                            channel_clock_select_bit <= wbyte;
                        `PAC_OFF_CNTWR:
                            // Either byte of a pair clears both halves.
                            cnt_clear <= wbyte
                                | ({pair[3], pair[3], pair[2], pair[2],
                                    pair[1], pair[1], pair[0], pair[0]}
                                   & {wbyte[6], wbyte[7], wbyte[4],
                                      wbyte[5], wbyte[2], wbyte[3],
                                      wbyte[0], wbyte[1]});
                        default: ;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @* begin
        case (aw_addr)
            `PAC_OFF_ALIGN, `PAC_OFF_CTRL, `PAC_OFF_ENABLE,
            `PAC_OFF_POLARITY, `PAC_OFF_CLKSEL, `PAC_OFF_CNTWR:
                werr = 1'b0;
            default: werr = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; unmapped addresses answer with a slave error and zero.
    always @* begin
        next_rerr = 1'b0;
        case (s_axi_araddr)
            `PAC_OFF_ALIGN:    next_rdata = channel_alignment_select;
            `PAC_OFF_CTRL:     next_rdata = pairing_and_low_power_control;
            `PAC_OFF_ENABLE:   next_rdata = channel_enable_bit;
            `PAC_OFF_POLARITY: next_rdata = channel_polarity_bit;
            `PAC_OFF_CLKSEL:   next_rdata = channel_clock_select_bit;
            `PAC_OFF_CNTWR:    next_rdata = `PAC_RST_BYTE;
            `PAC_OFF_STATUS:   next_rdata = pulse_output_port;
            default: begin
                next_rdata = `PAC_RST_BYTE;
                next_rerr  = 1'b1;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `PAC_RST_WORD;
            s_axi_rresp   <= `PAC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, next_rdata};
            s_axi_rresp   <= next_rerr ? `PAC_RESP_SLVERR : `PAC_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (sys_rst) begin
            center_align_bit <= `PAC_RST_BYTE;
            pair_mask        <= 4'h0;
            prescaler_clk_en <= 1'b1;
        end else begin
            center_align_bit <= eff_center;
            pair_mask        <= pair;
            prescaler_clk_en <= clk_run;
        end
    end
endmodule // pac_top
`default_nettype wire

// ---- test/pac_pin_model.sv ----
// Pin-side observer that counts rising edges on each output pin.
`default_nettype none
module pac_pin_model (
    input wire logic        clk,
    input wire logic [7:0]  pins,
    input wire logic        meas,
    output var logic [63:0] edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] prev;
    always_ff @(posedge clk) begin
        prev <= pins;
        if (!meas) edges <= 64'h0000_0000_0000_0000;
        else
            for (int g = 0; g < 8; g++)
                if (pins[g] && !prev[g])
                    edges[8*g +: 8] <= edges[8*g +: 8] + 8'h01;
    end
endmodule // pac_pin_model
`default_nettype wire

// ---- test/pac_props.sv ----
// Port-level checker of the alignment and pairing slice.
`include "pac_defines.vh"
`default_nettype none
module pac_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        wait_mode,
    input wire logic        freeze_mode,
    input wire logic [7:0]  pulse_output_port,
    input wire logic [7:0]  center_align_bit,
    input wire logic [3:0]  pair_mask,
    input wire logic        prescaler_clk_en
);
    logic [7:0] wa, ra, wd, al, ct, eff;
    logic       ws;
    logic [1:0] qt;
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies are taken at the write response; qt masks the window
    // from address acceptance until the design's outputs have settled.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            al <= 8'h00;
            ct <= 8'h00;
            qt <= 2'h0;
        end else begin
            if (qt != 2'h3) qt <= qt + 2'h1;
            if (s_axi_awvalid && s_axi_awready) begin
                wa <= s_axi_awaddr;
                qt <= 2'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd <= s_axi_wdata[7:0];
                ws <= s_axi_wstrb[0];
            end
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (s_axi_bvalid && s_axi_bready && ws &&
                s_axi_bresp == `PAC_RESP_OKAY) begin
                if (wa == `PAC_OFF_ALIGN) al <= wd;
                if (wa == `PAC_OFF_CTRL) ct <= wd & `PAC_CTRL_MASK;
                qt <= 2'h0;
            end
        end
    end
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            eff[2*g+1] = al[2*g+1];
            eff[2*g]   = ct[4+g] ? al[2*g+1] : al[2*g];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence aw_hs; s_axi_awvalid && s_axi_awready; endsequence
    sequence w_hs; s_axi_wvalid && s_axi_wready; endsequence
    sequence gated_s;
        ((wait_mode && ct[3]) || (freeze_mode && ct[2])) && qt == 2'h3;
    endsequence
    sequence free_s;
        !((wait_mode && ct[3]) || (freeze_mode && ct[2])) && qt == 2'h3;
    endsequence
    align_eff_a: assert property (
        qt == 2'h3 |-> center_align_bit == eff)
        else $error("effective alignment differs");
    pair_mask_a: assert property (
        qt == 2'h3 |-> pair_mask == ct[7:4])
        else $error("pair mask differs from control");
    pair_even_off_a: assert property (
        qt == 2'h3 |-> (pulse_output_port & {1'b0, ct[7], 1'b0, ct[6],
        1'b0, ct[5], 1'b0, ct[4]}) == 8'h00)
        else $error("high channel of a pair drives its pin");
    clk_gate_a: assert property (
        gated_s [*5] |-> !prescaler_clk_en)
        else $error("prescaler clock not gated");
    clk_resume_a: assert property (
        free_s [*5] |-> prescaler_clk_en)
        else $error("prescaler clock not running");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (
        aw_hs ##0 w_hs |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    ctrl_low_zero_a: assert property (
        s_axi_rvalid && ra == `PAC_OFF_CTRL |->
        (s_axi_rdata & 32'hFFFF_FF03) == 32'h0000_0000)
        else $error("control low bits not zero");
    align_readback_a: assert property (
        s_axi_rvalid && ra == `PAC_OFF_ALIGN |->
        s_axi_rdata == {24'h00_0000, al})
        else $error("alignment read back wrong");
endmodule // pac_props
bind pac_top pac_props pac_props_i (.*);
`default_nettype wire

// ---- test/pwm_align_concat_control_bench.sv ----
// Register-level regression of the alignment and pairing slice.
`include "pac_defines.vh"
`default_nettype none
module pwm_align_concat_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, meas = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, prescale_tick = 1'b1;
    logic wait_mode = 1'b0, freeze_mode = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1, pair_mask;
    logic [63:0] period_bytes = 64'h0404_0404_0404_0801;
    logic [63:0] duty_bytes = 64'h0101_0101_0101_0201, edges;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, prescaler_clk_en;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pulse_output_port, center_align_bit, ex;
    int error_cnt = 0, comparisons = 0;
    always #20 clk = ~clk;
    pac_top pac_top_i (.*);
    pac_pin_model pac_pin_model_i (.clk(clk), .pins(pulse_output_port),
        .meas(meas), .edges(edges));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where the values equal
    // those the next rising edge samples, so no race with the design.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        logic ah, wh, bh;
        logic [1:0] r;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) begin
                s_axi_bready <= 1'b0;
                check("bresp", {30'h0, r}, {30'h0, e});
                return;
            end
        end
        error_cnt++;
        tally_and_finish();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] e);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) begin
                s_axi_rready <= 1'b0;
                check("rdata", d, x);
                check("rresp", {30'h0, r}, {30'h0, e});
                return;
            end
        end
        error_cnt++;
        tally_and_finish();
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic measure;
        @(posedge clk) meas <= 1'b0;
        @(posedge clk) meas <= 1'b1;
        settle(64);
    endtask
    // Window edges may cut one period short, so one edge of slack.
    task automatic near(input int g, input int x);
        logic [7:0] e;
        e = edges[8*g +: 8];
        check("edges", {31'h0, (e + 1 >= x) && (e <= x + 1)}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        settle(10);
        @(posedge clk) sys_rst <= 1'b0;
        rd(`PAC_OFF_ALIGN, `PAC_RST_WORD, `PAC_RESP_OKAY);
        rd(`PAC_OFF_CTRL, `PAC_RST_WORD, `PAC_RESP_OKAY);
        check("clk_en", {31'h0, prescaler_clk_en}, 32'h1);
        wr(`PAC_OFF_ALIGN, 32'h0000_00A5, `PAC_RESP_OKAY);
        rd(`PAC_OFF_ALIGN, 32'h0000_00A5, `PAC_RESP_OKAY);
        wr(`PAC_OFF_CTRL, 32'hFFFF_FFFF, `PAC_RESP_OKAY);
        rd(`PAC_OFF_CTRL, 32'h0000_00FC, `PAC_RESP_OKAY);
        wr(8'h40, 32'h0000_0001, `PAC_RESP_SLVERR);
        rd(8'h40, `PAC_RST_WORD, `PAC_RESP_SLVERR);
        $display("test registers done");
        for (int g = 0; g < 4; g++) begin
            wr(`PAC_OFF_CTRL, 32'h0000_0010 << g, `PAC_RESP_OKAY);
            settle(4);
            ex = 8'hA5;
            ex[2*g] = ex[2*g+1];
            check("pair", {28'h0, pair_mask}, 32'h1 << g);
            check("align", {24'h0, center_align_bit}, {24'h0, ex});
        end
        $display("test pairing done");
        wr(`PAC_OFF_CTRL, `PAC_RST_WORD, `PAC_RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            wr(`PAC_OFF_ENABLE, `PAC_RST_WORD, `PAC_RESP_OKAY);
            wr(`PAC_OFF_ALIGN, k ? 32'h0000_00F0 : 32'h0000_000F,
               `PAC_RESP_OKAY);
            wr(`PAC_OFF_ENABLE, 32'h0000_00FF, `PAC_RESP_OKAY);
            measure();
            for (int g = 2; g < 8; g++)
                near(g, ((g < 4) ^ k) ? 8 : 16);
        end
        wr(`PAC_OFF_ENABLE, `PAC_RST_WORD, `PAC_RESP_OKAY);
        wr(`PAC_OFF_CTRL, 32'h0000_00F0, `PAC_RESP_OKAY);
        wr(`PAC_OFF_ENABLE, 32'h0000_00FF, `PAC_RESP_OKAY);
        measure();
        for (int g = 0; g < 4; g++) begin
            check("even", {24'h0, edges[16*g +: 8]}, 32'h0);
            near(2*g+1, 0);
        end
        $display("test waveforms done");
        wr(`PAC_OFF_ENABLE, `PAC_RST_WORD, `PAC_RESP_OKAY);
        wr(`PAC_OFF_CTRL, `PAC_RST_WORD, `PAC_RESP_OKAY);
        wr(`PAC_OFF_ENABLE, 32'h0000_00FF, `PAC_RESP_OKAY);
        @(posedge clk) wait_mode <= 1'b1;
        settle(6);
        check("clk_en", {31'h0, prescaler_clk_en}, 32'h1);
        wr(`PAC_OFF_CTRL, 32'h0000_0008, `PAC_RESP_OKAY);
        settle(6);
        check("clk_en", {31'h0, prescaler_clk_en}, 32'h0);
        measure();
        near(1, 0);
        @(posedge clk) wait_mode <= 1'b0;
        settle(6);
        check("clk_en", {31'h0, prescaler_clk_en}, 32'h1);
        @(posedge clk) freeze_mode <= 1'b1;
        wr(`PAC_OFF_CTRL, 32'h0000_0004, `PAC_RESP_OKAY);
        settle(6);
        check("clk_en", {31'h0, prescaler_clk_en}, 32'h0);
        rd(`PAC_OFF_CTRL, 32'h0000_0004, `PAC_RESP_OKAY);
        measure();
        near(1, 0);
        wr(`PAC_OFF_CNTWR, 32'h0000_0002, `PAC_RESP_OKAY);
        settle(3);
        check("pin1", {31'h0, pulse_output_port[1]}, 32'h0);
        @(posedge clk) freeze_mode <= 1'b0;
        settle(6);
        check("clk_en", {31'h0, prescaler_clk_en}, 32'h1);
        measure();
        near(1, 8);
        $display("test low power done");
        tally_and_finish();
    end
endmodule // pwm_align_concat_control_bench
`default_nettype wire
